// ### hw/adcs_regs.vh
// Register offsets, field positions, reset values and timing counts for the converter sequencer.
// Assumes a 32-bit APB slave with one register per aligned word.
`ifndef ADCS_REGS_VH
`define ADCS_REGS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADCS_OFF_CTRL0    12'h000
`define ADCS_OFF_CTRL1    12'h004
`define ADCS_OFF_RESULT   12'h008
`define ADCS_OFF_PORT     12'h00c
`define ADCS_OFF_DIR      12'h010
`define ADCS_OFF_IRQ      12'h014

// ----------------------------------------
// Control register 0 fields
// ----------------------------------------
`define ADCS_C0_POWER     0
`define ADCS_C0_GO        2
`define ADCS_C0_CHS_LO    3
`define ADCS_C0_CHS_HI    5
`define ADCS_C0_CKS_LO    6
`define ADCS_C0_CKS_HI    7
`define ADCS_C0_MASK      8'hfd

// ----------------------------------------
// Control register 1 and interrupt register fields
// ----------------------------------------
`define ADCS_C1_W         2
`define ADCS_C1_RESET     2'h0
`define ADCS_IRQ_FLAG     0
`define ADCS_IRQ_EN       1
`define ADCS_IRQ_GEN      2

// ----------------------------------------
// Port and timing
// ----------------------------------------
`define ADCS_PORT_W       5
`define ADCS_DIR_RESET    5'h1f
`define ADCS_CKS_RC       2'h3
`define ADCS_DIV2         8'h02
`define ADCS_DIV8         8'h08
`define ADCS_DIV32        8'h20
`define ADCS_RC_DIV       8'ha0
`define ADCS_HALF_BITS    5'h13

`endif

// ### hw/adcs_clkdiv.v
// Bit-period divider for the converter sequencer.
// Assumes pclk stands for the oscillator; the RC option is a fixed division of the same clock.
`include "adcs_regs.vh"

module adcs_clkdiv (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       run,
  input  wire [1:0] clk_sel,
  output reg        half_tick
);

  reg  [7:0] cnt_q;
  wire [7:0] half_len;

  // ----------------------------------------
  // Half-period length per clock choice
  // ----------------------------------------
  // Ticks every half bit period so 9.5 periods are counted exactly.
  assign half_len = (clk_sel == 2'h0) ? (`ADCS_DIV2 >> 1) :
                    (clk_sel == 2'h1) ? (`ADCS_DIV8 >> 1) :
                    (clk_sel == 2'h2) ? (`ADCS_DIV32 >> 1) : (`ADCS_RC_DIV >> 1);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= 8'h00;
      half_tick <= 1'b0;
    end else if (!run) begin
      cnt_q     <= 8'h00;
      half_tick <= 1'b0;
    end else if (cnt_q == half_len - 8'h01) begin
      cnt_q     <= 8'h00;
      half_tick <= 1'b1;
    end else begin
      cnt_q     <= cnt_q + 8'h01;
      half_tick <= 1'b0;
    end
  end

endmodule

// ### hw/adcs_sar.v
// Successive-approximation register stepping one bit per bit period.
// Assumes an external comparator answer, valid when sampled.
`include "adcs_regs.vh"

module adcs_sar (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       start,
  input  wire       step,
  input  wire       cmp_high,
  output reg  [7:0] trial,
  output reg        done
);

  reg [3:0] bit_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trial <= 8'h00;
      bit_q <= 4'h0;
      done  <= 1'b0;
    end else if (start) begin
      trial <= 8'h80;
      bit_q <= 4'h7;
      done  <= 1'b0;
    end else if (step && !done) begin
      // Keep or drop the trial bit, then try the next lower one.
      trial[bit_q[2:0]] <= cmp_high;
      if (bit_q != 4'h0) begin
        trial[bit_q[2:0] - 3'h1] <= 1'b1;
        bit_q <= bit_q - 4'h1;
      end else begin
        done <= 1'b1;
      end
    end
  end

endmodule

// ### hw/adcs_top.v
// Converter sequencer with the five-pin port, reached over APB.
// Assumes pins and comparator answer are synchronous to pclk and pclk stands for the oscillator.
`include "adcs_regs.vh"

module adcs_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [4:0]  pin_in,
  output reg  [4:0]  pin_out,
  output reg  [4:0]  pin_oe,
  output reg  [2:0]  channel_select,
  input  wire        cmp_high,
  output reg  [7:0]  dac_trial,
  output reg         conv_irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  reg        state_q;
  reg  [7:0] ctrl0_q;
  reg  [1:0] ctrl1_q;
  reg  [7:0] result_q;
  reg  [4:0] latch_q;
  reg  [4:0] dir_q;
  reg        irq_flag_q;
  reg        irq_en_q;
  reg        gie_q;
  reg  [4:0] halves_q;
  reg        sar_start_q;
  wire       half_tick;
  wire [7:0] sar_trial;
  wire       sar_done;
  wire       wr_en;
  wire       rd_en;
  wire       acc_first;
  wire       go_set;
  wire       conv_end;
  wire [4:0] analog_mask;
  wire [4:0] port_view;

  // ----------------------------------------
  // Pin function decode
  // ----------------------------------------
  // Which of the four lower pins are analog for each pin-mode code; pin 4 is always digital.
  function [4:0] analog_of;
    input [1:0] mode;
    begin
      case (mode)
        2'h0: analog_of = 5'h0f;
        2'h1: analog_of = 5'h0f;
        2'h2: analog_of = 5'h03;
        default: analog_of = 5'h00;
      endcase
    end
  endfunction

  // True for the six register words; anything else is refused on write and reads as zero.
  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `ADCS_OFF_CTRL0) || (a == `ADCS_OFF_CTRL1) || (a == `ADCS_OFF_RESULT) ||
                  (a == `ADCS_OFF_PORT) || (a == `ADCS_OFF_DIR) || (a == `ADCS_OFF_IRQ);
    end
  endfunction

  assign analog_mask = analog_of(ctrl1_q);
  assign port_view   = pin_in & ~analog_mask;

  // Writes land at the edge where pready is high, so the master and the slave agree on the edge.
  assign acc_first = psel && penable && !pready;
  assign wr_en     = psel && penable && pwrite && pready;
  assign rd_en    = psel && !penable;
  assign go_set   = wr_en && (paddr == `ADCS_OFF_CTRL0) && pwdata[`ADCS_C0_GO];
  assign conv_end = (state_q == ST_CONV) && half_tick && (halves_q == `ADCS_HALF_BITS - 5'h01);

  // ----------------------------------------
  // Divider and approximation register
  // ----------------------------------------
  adcs_clkdiv u_div (
    .pclk      (pclk),
    .presetn   (presetn),
    .run       (state_q == ST_CONV),
    .clk_sel   (ctrl0_q[`ADCS_C0_CKS_HI:`ADCS_C0_CKS_LO]),
    .half_tick (half_tick)
  );

  // The comparator sees whatever is on the selected pin, driven or not; no channel or direction gating.
  adcs_sar u_sar (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (sar_start_q),
    .step     (half_tick && halves_q[0] && (halves_q < 5'h10)),
    .cmp_high (cmp_high),
    .trial    (sar_trial),
    .done     (sar_done)
  );

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= ST_IDLE;
      halves_q    <= 5'h00;
      sar_start_q <= 1'b0;
      result_q    <= 8'h00;
    end else begin
      sar_start_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (go_set && pwdata[`ADCS_C0_POWER]) begin
            state_q     <= ST_CONV;
            halves_q    <= 5'h00;
            sar_start_q <= 1'b1;
          end
        end
        default: begin
          if (half_tick) begin
            halves_q <= halves_q + 5'h01;
          end
          if (conv_end || !ctrl0_q[`ADCS_C0_POWER]) begin
            state_q <= ST_IDLE;
          end
          if (conv_end && sar_done) begin
            result_q <= sar_trial;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers and APB
  // ----------------------------------------
  // Done is a one-cycle answer to keep bus timing fixed; the write lands at the pready edge.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_q    <= 8'h00;
      ctrl1_q    <= `ADCS_C1_RESET;
      latch_q    <= 5'h00;
      dir_q      <= `ADCS_DIR_RESET;
      irq_flag_q <= 1'b0;
      irq_en_q   <= 1'b0;
      gie_q      <= 1'b0;
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= acc_first && pwrite && !is_mapped(paddr);
      if (wr_en) begin
        if (paddr == `ADCS_OFF_CTRL0) begin
          ctrl0_q <= pwdata[7:0] & `ADCS_C0_MASK;
          if (!pwdata[`ADCS_C0_POWER] || !(pwdata[`ADCS_C0_GO] || state_q == ST_CONV)) begin
            ctrl0_q[`ADCS_C0_GO] <= 1'b0;
          end else begin
            ctrl0_q[`ADCS_C0_GO] <= 1'b1;
          end
        end else if (paddr == `ADCS_OFF_CTRL1) begin
          ctrl1_q <= pwdata[1:0];
        end else if (paddr == `ADCS_OFF_PORT) begin
          // Unwritten bits take the pin levels as read back at the write, and hold them until the next port write.
          latch_q <= (port_view & ~pwdata[12:8]) | (pwdata[4:0] & pwdata[12:8]);
        end else if (paddr == `ADCS_OFF_DIR) begin
          dir_q <= pwdata[4:0];
        end else if (paddr == `ADCS_OFF_IRQ) begin
          irq_en_q <= pwdata[`ADCS_IRQ_EN];
          gie_q    <= pwdata[`ADCS_IRQ_GEN];
        end
      end
      if (conv_end) begin
        ctrl0_q[`ADCS_C0_GO] <= 1'b0;
      end
      // Hardware set wins over a software clear in the same cycle.
      if (conv_end) begin
        irq_flag_q <= 1'b1;
      end else if (wr_en && paddr == `ADCS_OFF_IRQ) begin
        irq_flag_q <= pwdata[`ADCS_IRQ_FLAG];
      end
      if (rd_en) begin
        if (paddr == `ADCS_OFF_CTRL0) begin
          prdata <= {24'h000000, ctrl0_q};
        end else if (paddr == `ADCS_OFF_CTRL1) begin
          prdata <= {30'h00000000, ctrl1_q};
        end else if (paddr == `ADCS_OFF_RESULT) begin
          prdata <= {24'h000000, result_q};
        end else if (paddr == `ADCS_OFF_PORT) begin
          prdata <= {27'h0000000, port_view};
        end else if (paddr == `ADCS_OFF_DIR) begin
          prdata <= {27'h0000000, dir_q};
        end else if (paddr == `ADCS_OFF_IRQ) begin
          prdata <= {29'h00000000, gie_q, irq_en_q, irq_flag_q};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  // ----------------------------------------
  // Pin drivers and outputs
  // ----------------------------------------
  // Pin 4 can only pull low, so a latched one leaves it floating.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out        <= 5'h00;
      pin_oe         <= 5'h00;
      channel_select <= 3'h0;
      dac_trial      <= 8'h00;
      conv_irq       <= 1'b0;
    end else begin
      pin_out        <= {1'b0, latch_q[3:0]};
      pin_oe         <= {~dir_q[4] & ~latch_q[4], ~dir_q[3:0]};
      channel_select <= ctrl0_q[`ADCS_C0_CHS_HI:`ADCS_C0_CHS_LO];
      dac_trial      <= sar_trial;
      conv_irq       <= irq_flag_q && irq_en_q && gie_q;
    end
  end

endmodule

// ### verif/adcs_src.sv
// Far-side model: analog sources per channel and the wiring of the five port pins.
// Assumes the bench sets the channel levels and the outside pin levels.
module adcs_src (
  input  logic [63:0] levels,
  input  logic [2:0]  channel_select,
  input  logic [7:0]  dac_trial,
  input  logic [4:0]  pin_out,
  input  logic [4:0]  pin_oe,
  input  logic [4:0]  ext,
  output logic        cmp_high,
  output logic [4:0]  pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Model
  // ----
  assign cmp_high = levels[channel_select * 8 +: 8] >= dac_trial;
  // A released pin shows the outside level, so a stuck driver is never hidden.
  assign pin_in[3:0] = (pin_oe[3:0] & pin_out[3:0]) | (~pin_oe[3:0] & ext[3:0]);
  assign pin_in[4] = (pin_oe[4] && !pin_out[4]) ? 1'b0 : ext[4];
endmodule

// ### verif/adcs_top_monitor.sv
// Bus and pin checks for the converter block.
// Assumes one pclk domain with presetn as asynchronous active-low reset.
module adcs_top_monitor (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic [4:0]  pin_out,
  input logic [4:0]  pin_oe,
  input logic        conv_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // Checks
  // ----
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
  a_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
  a_one_wait: assert property (psel && penable && !$past(penable) |=> pready) else $error("wait state wrong");
  a_err_write: assert property (pslverr |-> pready && pwrite) else $error("pslverr misplaced");
  a_rdata_hold: assert property (psel && penable && $past(penable) |-> $stable(prdata)) else $error("prdata moved");
  a_pin4_drain: assert property (pin_out[4] == 1'b0) else $error("pin 4 driven high");
  a_reset_clean: assert property ($rose(presetn) |-> pin_oe == 5'h00 && !conv_irq) else $error("reset state");
  a_pins_by_write: assert property ($changed({pin_out, pin_oe}) |->
    $past(pready && pwrite) || $past(pready && pwrite, 2)) else $error("pins moved without write");
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(conv_irq));
  c_go: cover property (pready && pwrite && paddr == 12'h000 && pwdata[2]);
endmodule
bind adcs_top adcs_top_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_out(pin_out), .pin_oe(pin_oe), .conv_irq(conv_irq));

// ### verif/adcs_tb.sv
// Self-checking bench for the converter block over APB.
// Assumes adcs_top and adcs_src are compiled first; pclk stands for the oscillator.
`include "adcs_regs.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, cmp_high, conv_irq, errv;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdv;
  logic [4:0]  pin_in, pin_out, pin_oe, ext = 5'h1f;
  logic [2:0]  channel_select;
  logic [7:0]  dac_trial;
  logic [63:0] levels = 0;
  int          miscompares = 0, checks = 0, cyc = 0;
  adcs_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .channel_select(channel_select), .cmp_high(cmp_high), .dac_trial(dac_trial),
    .conv_irq(conv_irq));
  adcs_src u_src (.levels(levels), .channel_select(channel_select), .dac_trial(dac_trial), .pin_out(pin_out),
    .pin_oe(pin_oe), .ext(ext), .cmp_high(cmp_high), .pin_in(pin_in));
  initial forever #12.5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  // ----
  // Tasks
  // ----
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // The idle edge at entry keeps two transfers from assigning psel in one time step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      stop_test();
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("read", e, rdv)
  endtask
  task automatic t_reset();
    `CHK("oe", 5'h00, pin_oe)
    rdc(`ADCS_OFF_DIR, 32'h1f);
    rdc(`ADCS_OFF_CTRL1, 32'h0);
    rdc(`ADCS_OFF_PORT, 32'h10);
  endtask
  task automatic t_port();
    wr(`ADCS_OFF_CTRL1, 32'h3);
    wr(`ADCS_OFF_DIR, 32'h0);
    wr(`ADCS_OFF_PORT, 32'h1f15);
    @(posedge pclk);
    @(negedge pclk);
    `CHK("out", 5'h05, pin_out)
    `CHK("oe", 5'h0f, pin_oe)
    rdc(`ADCS_OFF_PORT, 32'h15);
    ext <= 5'h1e;
    wr(`ADCS_OFF_DIR, 32'h01);
    wr(`ADCS_OFF_PORT, 32'h0202);
    wr(`ADCS_OFF_DIR, 32'h0);
    @(posedge pclk);
    @(negedge pclk);
    `CHK("rmw", 5'h06, pin_out)
  endtask
  task automatic t_conv();
    int n, w, k, h;
    logic [7:0] lv;
    for (int c = 0; c < 4; c++) begin
      lv = 8'h3c + 8'h55 * c;
      h = (c == 0) ? 1 : (c == 1) ? 4 : (c == 2) ? 16 : 80;
      levels <= 64'(lv) << (16 * c + 8);
      wr(`ADCS_OFF_CTRL1, (c == 3) ? 32'h3 : 32'h0);
      wr(`ADCS_OFF_DIR, 32'h1f);
      wr(`ADCS_OFF_IRQ, 32'h6);
      // Every divide choice gives at least the minimum bit period at this clock rate.
      wr(`ADCS_OFF_CTRL0, 32'h01 | (c << 6) | ((2 * c + 1) << 3));
      repeat (4) @(posedge pclk);
      wr(`ADCS_OFF_CTRL0, 32'h05 | (c << 6) | ((2 * c + 1) << 3));
      w = cyc;
      k = 0;
      do begin
        apb(1'b0, `ADCS_OFF_CTRL0, 32'h0);
        k++;
      end while (rdv[2] !== 1'b0 && k < 1000);
      if (k >= 1000) begin
        miscompares++;
        stop_test();
      end
      n = cyc - 2 - w;
      `CHK("time", 1'b1, n >= 19 * h - 2 && n <= 20 * h + 6)
      `CHK("mux", 3'(2 * c + 1), channel_select)
      `CHK("irq", 1'b1, conv_irq)
      rdc(`ADCS_OFF_RESULT, 32'(lv));
      rdc(`ADCS_OFF_IRQ, 32'h7);
      wr(`ADCS_OFF_IRQ, 32'h6);
      @(posedge pclk);
      @(negedge pclk);
      `CHK("irqclr", 1'b0, conv_irq)
      repeat (4 * h) @(posedge pclk);
    end
  endtask
  task automatic t_refuse();
    wr(`ADCS_OFF_CTRL0, 32'h04);
    rdc(`ADCS_OFF_CTRL0, 32'h0);
    wr(12'h020, 32'h1);
    `CHK("slverr", 1'b1, errv)
    rdc(12'h020, 32'h0);
    `CHK("rderr", 1'b0, errv)
    wr(`ADCS_OFF_RESULT, 32'h55);
    rdc(`ADCS_OFF_RESULT, 32'h3b);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_port();
    t_conv();
    t_refuse();
    stop_test();
  end
endmodule
